// [rtl/rasq_pkg.sv]
/*
  constants shared by the register access sequencer: cycle counts derived
  from the documented delays, apb register offsets, field positions and
  reset values.
  assumes a 100 MHz mclk.
*/
package rasq_pkg;

  // ---------------------------------------------------------------
  // clock and delay timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;      // mclk period
  localparam int STROBE_DELAY_NS = 85;    // select to strobe
  localparam int STROBE_LEN_NS = 150;     // strobe length
  localparam int DESKEW_NS = 225;         // read data deskew
  localparam int TIMEOUT_NS = 1500;       // missing drive / summary wait

  // least times, rounded up to whole cycles
  localparam logic [7:0] STROBE_DELAY_CYC =
    8'((STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] STROBE_LEN_CYC =
    8'((STROBE_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] DESKEW_CYC =
    8'((DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] TIMEOUT_CYC =
    8'((TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET = 12'h000;   // base match + enable
  localparam logic [11:0] STATUS_OFFSET = 12'h004; // state, sticky flag

  // control fields
  localparam int CTRL_BASE_LSB = 0;      // base, host address 17..5
  localparam int CTRL_BASE_MSB = 12;
  localparam int CTRL_ENABLE_BIT = 16;   // decoder enable
  localparam logic [12:0] BASE_RESET = 13'h0000;
  localparam logic CTRL_ENABLE_RESET = 1'b0;

  // status fields
  localparam int STAT_MISSING_BIT = 0;   // live missing-drive flag
  localparam int STAT_STICKY_BIT = 1;    // sticky copy, write 1 clears
  localparam int STAT_REQ_BIT = 2;       // cycle request on drive bus
  localparam int STAT_SSYNC_BIT = 3;     // slave sync to host
  localparam int STAT_SELECT_BIT = 4;    // device select

  // host address split
  localparam int HADDR_MATCH_LSB = 5;
  localparam int HADDR_MATCH_MSB = 17;

  // sequencer states
  typedef enum logic [2:0]
  {
    RASQ_IDLE,
    RASQ_DELAY,
    RASQ_STROBE,
    RASQ_ARMED,
    RASQ_REQUEST,
    RASQ_DESKEW,
    RASQ_SYNC,
    RASQ_HANG
  } rasq_state_t;

endpackage : rasq_pkg

// [rtl/rasq_delay_timer.sv]
/*
  one down counter that times every fixed delay of the sequencer.
  assumes start and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module rasq_delay_timer
(
  input  wire logic       mclk,     // system clock
  input  wire logic       rstN,     // synchronised reset, active low
  input  wire logic       ce,       // clock enable
  input  wire logic       start,    // load length and run
  input  wire logic       clear,    // abort, wins over start
  input  wire logic [7:0] len,      // length in cycles, at least 1
  output logic            expire,   // high in the last counted cycle
  output logic            running   // count in progress
);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  logic [7:0] count_r;              // cycles still to run

  // counts len edges from the start edge; clear cancels at once
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      count_r <= 8'h00;
    else if (ce)
    begin
      if (clear)
        count_r <= 8'h00;
      else if (start)
        count_r <= len;
      else if (count_r != 8'h00)
        count_r <= count_r - 8'h01;
    end
  end

  assign expire = (count_r == 8'h01);
  assign running = (count_r != 8'h00);

endmodule : rasq_delay_timer

// [rtl/rasq_sequencer.sv]
/*
  register access sequencer: answers a host bus register access, strobes
  local registers and, unless inhibited, runs one control cycle on the drive bus, times out
  absent drives and returns slave sync. apb slave for base and status.
  assumes host and drive pins are asynchronous to mclk; decoder outputs
  (local, remote valid, shared, summary, function code, busy, unit and
  register select) come from logic on mclk.
*/
`timescale 1ns/1ps
module rasq_sequencer
(
  input  wire logic        mclk,              // system clock, 100 MHz
  input  wire logic        resetn,            // async reset, active low
  input  wire logic        ce,                // clock enable
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // host bus pins
  input  wire logic [17:0] hostAddr,
  input  wire logic        hostMasterSync,
  input  wire logic        hostWrite,         // write direction
  input  wire logic        hostByteWrite,     // byte write cycle
  input  wire logic [15:0] hostData,
  output logic             slaveSync,
  // adapter decoder and control, on mclk
  input  wire logic        localReg,
  input  wire logic        remoteValid,
  input  wire logic        sharedCtrlSel,     // shared control register
  input  wire logic        attnSummarySel,    // summary register
  input  wire logic        xferFuncCode,      // data transfer function
  input  wire logic        xferBusy,          // transfer in progress
  input  wire logic [2:0]  unitSelect,
  input  wire logic [4:0]  registerSelect,
  // drive bus
  input  wire logic        driveTransferAck,
  output logic             cycleRequest,
  output logic             directionToDrive,
  output logic [2:0]       driveUnitSelect,
  output logic [4:0]       registerSelectLines,
  output logic [15:0]      driveData,
  // adapter side
  output logic             deviceSelect,
  output logic             localStrobe,
  output logic             writeGate,
  output logic             cycleInhibit,
  output logic             cycleRequestArm,
  output logic             readDeskew,
  output logic             highByteWrite,
  output logic             missingDriveFlag
);

  // ---------------------------------------------------------------
  // reset and input synchronisers
  // ---------------------------------------------------------------
  logic [1:0]  rstSync_r;                      // reset release chain
  logic        rstN;                           // synchronised reset
  logic [37:0] pinMeta_r;                      // first stage, sync only
  logic [37:0] pinSync_r;                      // second stage
  logic [17:0] addrS;
  logic        msyncS;
  logic        writeS;
  logic        byteS;
  logic        ackS;

  // release reset through two flops
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rstSync_r <= 2'b00;
    else
      rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstN = rstSync_r[1];

  // two flops on every pin; address is stable well before sync arrives
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end
    else if (ce)
    begin
      pinMeta_r <= {hostAddr, hostMasterSync, hostWrite, hostByteWrite,
                    hostData, driveTransferAck};
      pinSync_r <= pinMeta_r;
    end
  end
  assign {addrS, msyncS, writeS, byteS} = pinSync_r[37:17];
  assign ackS = pinSync_r[0];

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic [12:0] base_r;                         // select match value
  logic        enable_r;                       // select enable
  logic        sticky_r;                       // missing drive seen
  logic        wrEn;
  logic        rdSetup;
  logic        ctrlHit;
  logic        statHit;

  assign ctrlHit = (paddr == rasq_pkg::CTRL_OFFSET);
  assign statHit = (paddr == rasq_pkg::STATUS_OFFSET);
  assign wrEn = psel & penable & pwrite;
  assign rdSetup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;                        // no wait states
  assign pslverr = psel & penable & ~(ctrlHit | statHit);

  // control register steers select decoding
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      base_r <= rasq_pkg::BASE_RESET;
      enable_r <= rasq_pkg::CTRL_ENABLE_RESET;
    end
    else if (ce && wrEn && ctrlHit)
    begin
      base_r <= pwdata[rasq_pkg::CTRL_BASE_MSB:rasq_pkg::CTRL_BASE_LSB];
      enable_r <= pwdata[rasq_pkg::CTRL_ENABLE_BIT];
    end
  end

  // sticky copy of the missing flag; a new set wins over a clear
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      sticky_r <= 1'b0;
    else if (ce)
    begin
      if (missingDriveFlag)
        sticky_r <= 1'b1;
      else if (wrEn && statHit && pwdata[rasq_pkg::STAT_STICKY_BIT])
        sticky_r <= 1'b0;
    end
  end

  // read data captured in setup, stands through the access phase
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      prdata <= 32'h00000000;
    else if (ce && rdSetup)
    begin
      prdata <= 32'h00000000;
      if (ctrlHit)
      begin
        prdata[rasq_pkg::CTRL_BASE_MSB:rasq_pkg::CTRL_BASE_LSB] <= base_r;
        prdata[rasq_pkg::CTRL_ENABLE_BIT] <= enable_r;
      end
      else if (statHit)
      begin
        prdata[rasq_pkg::STAT_MISSING_BIT] <= missingDriveFlag;
        prdata[rasq_pkg::STAT_STICKY_BIT] <= sticky_r;
        prdata[rasq_pkg::STAT_REQ_BIT] <= cycleRequest;
        prdata[rasq_pkg::STAT_SSYNC_BIT] <= slaveSync;
        prdata[rasq_pkg::STAT_SELECT_BIT] <= deviceSelect;
      end
    end
  end

  // ---------------------------------------------------------------
  // select, direction and inhibit decoding
  // ---------------------------------------------------------------
  logic addrMatch;
  logic inhibitNow;

  assign addrMatch = enable_r &&
    (addrS[rasq_pkg::HADDR_MATCH_MSB:rasq_pkg::HADDR_MATCH_LSB] == base_r);

  // any one case keeps the drive bus quiet
  assign inhibitNow = localReg
                    | ~remoteValid
                    | (highByteWrite & sharedCtrlSel)
                    | (writeS & xferFuncCode & xferBusy);

  // select only on match plus master sync; also clocks gate and flags
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      deviceSelect <= 1'b0;
      writeGate <= 1'b0;
      highByteWrite <= 1'b0;
      cycleInhibit <= 1'b0;
      directionToDrive <= 1'b0;
    end
    else if (ce)
    begin
      deviceSelect <= addrMatch & msyncS;
      writeGate <= addrMatch & msyncS & writeS;
      highByteWrite <= byteS & writeS & addrS[0];
      cycleInhibit <= inhibitNow;
      directionToDrive <= writeS;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  rasq_pkg::rasq_state_t state_r;
  logic       tStart;
  logic       tClear;
  logic [7:0] tLen;
  logic       tExpire;
  logic       selRise;
  logic       selPrev_r;

  // rising edge of select starts a sequence
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      selPrev_r <= 1'b0;
    else if (ce)
      selPrev_r <= deviceSelect;
  end
  assign selRise = deviceSelect & ~selPrev_r;

  // timer loads per state; a write acknowledge outside summary, or deselect, aborts it
  always_comb
  begin
    tStart = 1'b0;
    tLen = rasq_pkg::STROBE_DELAY_CYC;
    tClear = ~deviceSelect & (state_r != rasq_pkg::RASQ_IDLE);
    case (state_r)
      rasq_pkg::RASQ_IDLE:
      begin
        tStart = selRise;
      end
      rasq_pkg::RASQ_DELAY:
      begin
        tStart = tExpire;
        tLen = rasq_pkg::STROBE_LEN_CYC;
      end
      rasq_pkg::RASQ_ARMED:
      begin
        tStart = ~ackS;
        tLen = rasq_pkg::TIMEOUT_CYC;
      end
      rasq_pkg::RASQ_REQUEST:
      begin
        // a read acknowledge restarts the timer as the deskew
        if (ackS && !attnSummarySel)
        begin
          tClear = tClear | writeS;
          tStart = ~writeS;
          tLen = rasq_pkg::DESKEW_CYC;
        end
      end
      default:
      begin
        tStart = 1'b0;
      end
    endcase
  end

  rasq_delay_timer uTimer
  (
    .mclk    (mclk),
    .rstN    (rstN),
    .ce      (ce),
    .start   (tStart),
    .clear   (tClear),
    .len     (tLen),
    .expire  (tExpire),
    .running ()
  );

  // main state walk; losing select always returns to idle
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      state_r <= rasq_pkg::RASQ_IDLE;
    else if (ce)
    begin
      if (!deviceSelect && state_r != rasq_pkg::RASQ_IDLE)
        state_r <= rasq_pkg::RASQ_IDLE;
      else
        case (state_r)
          rasq_pkg::RASQ_IDLE:
            if (selRise)
              state_r <= rasq_pkg::RASQ_DELAY;
          rasq_pkg::RASQ_DELAY:
            if (tExpire)
              state_r <= rasq_pkg::RASQ_STROBE;
          rasq_pkg::RASQ_STROBE:
            if (tExpire)
              state_r <= cycleInhibit ? rasq_pkg::RASQ_SYNC
                                      : rasq_pkg::RASQ_ARMED;
          rasq_pkg::RASQ_ARMED:
            if (!ackS)
              state_r <= rasq_pkg::RASQ_REQUEST;
          rasq_pkg::RASQ_REQUEST:
            if (attnSummarySel)
            begin
              if (tExpire)
                state_r <= rasq_pkg::RASQ_SYNC;
            end
            else if (ackS)
              state_r <= writeS ? rasq_pkg::RASQ_SYNC
                                : rasq_pkg::RASQ_DESKEW;
            else if (tExpire)
              state_r <= rasq_pkg::RASQ_HANG;
          rasq_pkg::RASQ_DESKEW:
            if (tExpire)
              state_r <= rasq_pkg::RASQ_SYNC;
          rasq_pkg::RASQ_SYNC:
            state_r <= rasq_pkg::RASQ_SYNC;          // held till deselect
          rasq_pkg::RASQ_HANG:
            state_r <= rasq_pkg::RASQ_HANG;          // no sync, host times out
          default:
            state_r <= rasq_pkg::RASQ_IDLE;
        endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // drive bus address and data latched before request rises
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      driveUnitSelect <= 3'h0;
      registerSelectLines <= 5'h00;
      driveData <= 16'h0000;
    end
    else if (ce && state_r == rasq_pkg::RASQ_STROBE && tExpire)
    begin
      driveUnitSelect <= unitSelect;
      registerSelectLines <= registerSelect;
      driveData <= writeGate ? pinSync_r[16:1] : 16'h0000;
    end
  end

  // state decoded flags, all from flops
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      localStrobe <= 1'b0;
      cycleRequestArm <= 1'b0;
      cycleRequest <= 1'b0;
      readDeskew <= 1'b0;
      slaveSync <= 1'b0;
      missingDriveFlag <= 1'b0;
    end
    else if (ce)
    begin
      localStrobe <= (state_r == rasq_pkg::RASQ_DELAY && tExpire) ||
                     (state_r == rasq_pkg::RASQ_STROBE && !tExpire);
      cycleRequestArm <= (state_r == rasq_pkg::RASQ_STROBE && tExpire &&
                          !cycleInhibit) ||
                         (state_r == rasq_pkg::RASQ_ARMED && ackS);
      cycleRequest <= (state_r == rasq_pkg::RASQ_ARMED && !ackS) ||
                      (state_r == rasq_pkg::RASQ_REQUEST && deviceSelect &&
                       !(ackS && !attnSummarySel) && !tExpire);
      readDeskew <= (state_r == rasq_pkg::RASQ_REQUEST && ackS &&
                     !attnSummarySel && !writeS) ||
                    (state_r == rasq_pkg::RASQ_DESKEW && !tExpire);
      // sync holds until master sync drops and select falls
      if (!deviceSelect)
        slaveSync <= 1'b0;
      else if ((state_r == rasq_pkg::RASQ_STROBE && tExpire && cycleInhibit) ||
               (state_r == rasq_pkg::RASQ_REQUEST && !attnSummarySel &&
                ackS && writeS) ||
               (state_r == rasq_pkg::RASQ_REQUEST && attnSummarySel &&
                tExpire) ||
               (state_r == rasq_pkg::RASQ_DESKEW && tExpire))
        slaveSync <= 1'b1;
      // missing flag: set on timeout, then held in hang until deselect clears it
      if (!deviceSelect)
        missingDriveFlag <= 1'b0;
      else if (state_r == rasq_pkg::RASQ_REQUEST && ackS)
        missingDriveFlag <= 1'b0;
      else if (state_r == rasq_pkg::RASQ_REQUEST && tExpire &&
               !attnSummarySel && !ackS)
        missingDriveFlag <= 1'b1;
    end
  end

endmodule : rasq_sequencer

// [verification/rasq_sequencer_sva.sv]
/*
  assertion checker on the sequencer ports.
  assumes it is bound onto rasq_sequencer with mclk at 100 MHz.
*/
`timescale 1ns/1ps
module rasq_sequencer_sva
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        deviceSelect,
  input wire logic        localStrobe,
  input wire logic        cycleInhibit,
  input wire logic        cycleRequestArm,
  input wire logic        cycleRequest,
  input wire logic        driveTransferAck,
  input wire logic        attnSummarySel,
  input wire logic        readDeskew,
  input wire logic        slaveSync,
  input wire logic        missingDriveFlag,
  input wire logic [2:0]  driveUnitSelect,
  input wire logic [4:0]  registerSelectLines,
  input wire logic [15:0] driveData
);
  // ---------------
  // helper count
  // ---------------
  logic [7:0] reqCnt_r;  // request cycles in this select
  // cleared on deselect so each access counts afresh; saturates
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      reqCnt_r <= 8'h00;
    else if (!deviceSelect)
      reqCnt_r <= 8'h00;
    else if (cycleRequest && reqCnt_r != 8'hFF)
      reqCnt_r <= reqCnt_r + 8'h01;
  end
  // ---------------
  // properties
  // ---------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_strobe_delay: assert property ($rose(deviceSelect) |-> ##[9:10] $rose(localStrobe))
    else $error("strobe late or early after select");
  a_strobe_len: assert property ($rose(localStrobe) |-> ##14 localStrobe ##1 !localStrobe)
    else $error("strobe length wrong");
  a_inhibit_noarm: assert property (deviceSelect && cycleInhibit |-> !cycleRequestArm)
    else $error("arm while inhibited");
  a_local_sync: assert property ($fell(localStrobe) && cycleInhibit |-> ##[0:2] slaveSync)
    else $error("no sync after local strobe");
  a_bus_stable: assert property ($rose(cycleRequest) |->
    $stable(driveData) && $stable(driveUnitSelect) && $stable(registerSelectLines))
    else $error("drive bus not set up before request");
  a_req_ack_low: assert property ($rose(cycleRequest) |-> !$past(driveTransferAck, 3))
    else $error("request raised while acknowledge high");
  a_deskew_sync: assert property ($rose(readDeskew) |-> ##[23:25] $rose(slaveSync))
    else $error("deskew length wrong");
  a_missing_time: assert property ($rose(missingDriveFlag) |->
    reqCnt_r >= 8'h96 && reqCnt_r <= 8'h98 && !slaveSync)
    else $error("missing drive flag timing wrong");
  a_summary_wait: assert property ($rose(slaveSync) && attnSummarySel |->
    reqCnt_r >= 8'h96 && reqCnt_r <= 8'h98)
    else $error("summary sync not after fixed wait");
  a_deselect_clr: assert property ($fell(deviceSelect) |->
    ##[0:1] (!missingDriveFlag && !slaveSync))
    else $error("deselect left flag or sync set");
endmodule : rasq_sequencer_sva

bind rasq_sequencer rasq_sequencer_sva u_sva
(
  .mclk, .resetn, .deviceSelect, .localStrobe, .cycleInhibit, .cycleRequestArm,
  .cycleRequest, .driveTransferAck, .attnSummarySel, .readDeskew, .slaveSync, .missingDriveFlag,
  .driveUnitSelect, .registerSelectLines, .driveData
);

// [verification/rasq_drive_model.sv]
/*
  drive model: answers a request for its own unit after a set delay.
  assumes request and unit select come from the sequencer on mclk.
*/
`timescale 1ns/1ps
module rasq_drive_model
#(
  parameter logic [2:0] OWN_UNIT = 3'h2  // unit this drive answers to
)
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       cycleRequest,
  input  wire logic [2:0] driveUnitSelect,
  input  wire logic [7:0] ackDelay,     // cycles before answering
  output logic            transferAck
);
  logic [7:0] waitCnt_r;  // cycles since request seen
  // ack held until request falls, so a next cycle has to wait for it
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      waitCnt_r   <= 8'h00;
      transferAck <= 1'b0;
    end
    else if (!cycleRequest)
    begin
      waitCnt_r   <= 8'h00;
      transferAck <= 1'b0;
    end
    else if (driveUnitSelect == OWN_UNIT)
    begin
      if (waitCnt_r == ackDelay)
        transferAck <= 1'b1;
      else
        waitCnt_r <= waitCnt_r + 8'h01;
    end
  end
endmodule : rasq_drive_model

// [verification/rasq_sequencer_tb.sv]
/*
  self-checking bench for rasq_sequencer with one drive model.
  assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
module rasq_sequencer_tb;
  // ---------------
  // signals
  // ---------------
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        hostMasterSync, hostWrite, hostByteWrite, slaveSync, driveTransferAck;
  logic        cycleRequest, directionToDrive, deviceSelect, localStrobe, writeGate;
  logic        cycleInhibit, cycleRequestArm, readDeskew, highByteWrite, missingDriveFlag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [17:0] hostAddr;
  logic [15:0] hostData, driveData;
  logic [7:0]  ackDelay;   // drive answer delay
  logic [5:0]  decIn;      // local, remote valid, shared, summary, func, busy
  logic [4:0]  registerSelectLines;
  logic [2:0]  unitSelect, driveUnitSelect;
  logic [24:0] busAtReq;   // direction, unit, select, data at request
  int          n_errors, cmp_count, reqSeen, gateSeen, deskSeen, strbSeen, lo;

  rasq_sequencer dut
  (
    .mclk, .resetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .hostAddr, .hostMasterSync, .hostWrite, .hostByteWrite,
    .hostData, .slaveSync, .localReg(decIn[5]), .remoteValid(decIn[4]),
    .sharedCtrlSel(decIn[3]), .attnSummarySel(decIn[2]), .xferFuncCode(decIn[1]),
    .xferBusy(decIn[0]), .unitSelect, .registerSelect(5'h0B), .driveTransferAck,
    .cycleRequest, .directionToDrive, .driveUnitSelect, .registerSelectLines,
    .driveData, .deviceSelect, .localStrobe, .writeGate, .cycleInhibit,
    .cycleRequestArm, .readDeskew, .highByteWrite, .missingDriveFlag
  );
  rasq_drive_model drive
  (
    .mclk, .resetn, .cycleRequest, .driveUnitSelect, .ackDelay,
    .transferAck(driveTransferAck)
  );

  // ---------------
  // clock, monitor
  // ---------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // high-cycle counts, cleared by each host cycle
  always @(posedge mclk)
  begin
    if (cycleRequest === 1'b1 && reqSeen == 0)
      busAtReq = {directionToDrive, driveUnitSelect, registerSelectLines, driveData};
    reqSeen += int'(cycleRequest === 1'b1);
    gateSeen += int'(writeGate === 1'b1);
    deskSeen += int'(readDeskew === 1'b1);
    strbSeen += int'(localStrobe === 1'b1);
  end

  // ---------------
  // tasks
  // ---------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input int v, input int vlo, input int vhi);
    cmp_count++;
    if (v < vlo || v > vhi)
    begin
      n_errors++;
      $display("mismatch at %0t: %0d outside %0d..%0d", $time, v, vlo, vhi);
    end
  endtask : rng
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one host cycle; address leads master sync by 150 ns
  task automatic host(input logic wr, input logic bw, input logic [2:0] unit,
                      output int cyc, output logic miss);
    int n;
    hostAddr      <= {13'h0123, 4'h0, bw};
    hostWrite     <= wr;
    hostByteWrite <= bw;
    unitSelect    <= unit;
    reqSeen = 0;
    gateSeen = 0;
    deskSeen = 0;
    strbSeen = 0;
    repeat (15) @(posedge mclk);
    hostMasterSync <= 1'b1;
    cyc = 0;
    while (slaveSync !== 1'b1 && cyc < 400)
    begin
      @(posedge mclk);
      cyc++;
    end
    miss = missingDriveFlag;
    hostMasterSync <= 1'b0;
    n = 0;
    while ((deviceSelect !== 1'b0 || slaveSync !== 1'b0) && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    chk(32'(slaveSync), 32'h0);
    chk(32'(missingDriveFlag), 32'h0);
  endtask : host

  // ---------------
  // scenarios
  // ---------------
  task automatic t_regs;
    logic [31:0] rd;
    logic        err;
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk(rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h000, 32'h00010123, rd, err);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk(rd, 32'h00010123);
    $display("test registers done");
  endtask : t_regs
  task automatic t_inhibit;
    logic [5:0] cases [4] = '{6'h30, 6'h00, 6'h18, 6'h13};
    int         cyc;
    logic       miss;
    for (int i = 0; i < 4; i++)
    begin
      decIn <= cases[i];
      host(1'b1, i == 2, 3'h2, cyc, miss);
      rng(reqSeen, 0, 0);
      rng(strbSeen, 15, 15);
      rng(cyc, lo, lo + 5);
      rng(gateSeen, 1, 400);
    end
    $display("test inhibit done");
  endtask : t_inhibit
  task automatic t_write;
    int   cyc;
    logic miss;
    decIn    <= 6'h10;
    ackDelay <= 8'h03;
    host(1'b1, 1'b0, 3'h2, cyc, miss);
    chk({7'h00, busAtReq}, 32'h014BA5C3);
    rng(cyc, lo + 3, lo + 14);
    chk(32'(miss), 32'h0);
    $display("test remote write done");
  endtask : t_write
  task automatic t_read;
    int   cyc;
    logic miss;
    ackDelay <= 8'h28;
    host(1'b0, 1'b0, 3'h2, cyc, miss);
    rng(deskSeen, 23, 24);
    chk({7'h00, busAtReq}, 32'h004B0000);
    rng(cyc, lo + 63, lo + 80);
    rng(gateSeen, 0, 0);
    chk(32'(miss), 32'h0);
    $display("test remote read done");
  endtask : t_read
  task automatic t_summary;
    int   cyc;
    logic miss;
    decIn    <= 6'h14;
    ackDelay <= 8'h03;
    host(1'b0, 1'b0, 3'h2, cyc, miss);
    rng(cyc, lo + 150, lo + 160);
    chk(32'(miss), 32'h0);
    $display("test summary done");
  endtask : t_summary
  task automatic t_absent;
    int          cyc;
    logic        miss, err;
    logic [31:0] rd;
    decIn <= 6'h10;
    host(1'b1, 1'b0, 3'h5, cyc, miss);
    rng(cyc, 400, 400);
    chk(32'(miss), 32'h1);
    apb(1'b0, 12'h004, 32'h0, rd, err);
    chk(32'(rd[1]), 32'h1);
    apb(1'b1, 12'h004, 32'h2, rd, err);
    apb(1'b0, 12'h004, 32'h0, rd, err);
    chk(32'(rd[1]), 32'h0);
    $display("test absent drive done");
  endtask : t_absent
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // ---------------
  // main, watchdog
  // ---------------
  initial
  begin
    {psel, penable, pwrite, hostMasterSync, hostWrite, hostByteWrite} = '0;
    paddr = '0;
    pwdata = '0;
    hostAddr = '0;
    hostData = 16'hA5C3;
    decIn = '0;
    unitSelect = '0;
    ackDelay = 8'h03;
    resetn = 1'b0;
    lo = 2 + int'(rasq_pkg::STROBE_DELAY_CYC) + int'(rasq_pkg::STROBE_LEN_CYC);
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_inhibit();
    t_write();
    t_read();
    t_summary();
    t_absent();
    final_report();
  end
  // whole run is about a thousand cycles
  initial
  begin
    #100000;
    n_errors++;
    final_report();
  end
endmodule : rasq_sequencer_tb
